// *** rtl/dtm_bank_timer.sv ***
`timescale 1ns/100ps
module dtm_bank_timer
  import dtm_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic load,
  input wire logic [7:0] value,
  output logic done
);
  typedef struct packed {
    logic [7:0] cnt;
  } dtm_bt_s;
  dtm_bt_s st_q;
  dtm_bt_s st_d;

  // Counts down a loaded spacing; done when it reaches zero.
  always_comb
  begin
    st_d = st_q;
    if (load)
    begin
      st_d.cnt = value;
    end
    else if (st_q.cnt != 8'h00)
    begin
      st_d.cnt = st_q.cnt - 8'h01;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      st_q <= '{cnt: CNT_RST};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign done = (st_q.cnt == 8'h00);
endmodule

// *** rtl/dtm_ctrl.sv ***
`timescale 1ns/100ps
module dtm_ctrl
  import dtm_pkg::*;
#(
  parameter int AW = 14,
  parameter int DW = 8,
  parameter int AL = 0,
  parameter int TREFI = TREFI_CK
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic reqValid,
  input wire logic reqWrite,
  input wire logic reqChop,
  input wire logic [2:0] reqBank,
  input wire logic [AW-1:0] reqRow,
  input wire logic [AW-1:0] reqCol,
  input wire logic [DW-1:0] reqData,
  input wire logic [DW/8-1:0] reqMask,
  input wire logic [1:0] blMode,
  output logic reqReady,
  output logic [DW-1:0] rspData,
  output logic rspValid,
  output logic refBusy,
  dtm_if.ctrl mem
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b000, S_ACT = 3'b001, S_COL = 3'b010, S_PRE = 3'b011,
    S_REF = 3'b100, S_MRS = 3'b101, S_INIT = 3'b110
  } dtm_st_e;
  typedef struct packed {
    dtm_st_e st;
    logic [7:0] wait_;
    logic signed [4:0] debt;
    logic [11:0] refiCnt;
    logic [3:0] beats;
    logic [7:0] wcnt;
    logic wr;
    logic chop;
    logic [2:0] bank;
    logic [AW-1:0] col;
    logic [DW-1:0] data;
    logic [DW/8-1:0] mask;
    logic [3:0] cmd;
    logic [AW-1:0] addr;
    logic [2:0] ba;
    logic [DW-1:0] rdat;
    logic rval;
  } dtm_c_s;
  dtm_c_s q;
  dtm_c_s d;

  // Returns the wait before precharge after a column command.
  function automatic logic [7:0] preGap(input logic wr, input logic [3:0] beats);
    if (wr)
      preGap = 8'(WL_CK + AL) + 8'(beats >> 1) + 8'(TWR_CK);
    else
      preGap = 8'(AL + TRTP_CK);
  endfunction

  // Sequences one closed-page access, refreshing when the debt demands it.
  always_comb
  begin
    d = q;
    d.cmd = CMD_NOP;
    d.rval = 1'b0;
    if (q.refiCnt == 12'(TREFI - 1))
    begin
      d.refiCnt = 12'h000;
      d.debt = q.debt + 5'sd1;
    end
    else
    begin
      d.refiCnt = q.refiCnt + 12'h001;
    end
    if (mem.rvalid)
    begin
      d.rdat = mem.rdata;
      d.rval = 1'b1;
    end
    if (q.wcnt != 8'h00)
    begin
      d.wcnt = q.wcnt - 8'h01;
    end
    if (q.wait_ != 8'h00)
    begin
      d.wait_ = q.wait_ - 8'h01;
    end
    else
    begin
      case (q.st)
        S_INIT:
        begin
          d.cmd = CMD_MRS;
          d.addr = '0;
          d.addr[1:0] = blMode;
          d.st = S_IDLE;
          d.wait_ = 8'(TCCD_CK);
        end
        S_IDLE:
        begin
          // Refresh owed at the postpone limit is forced ahead of traffic.
          if (q.debt >= 5'sd1 && (q.debt >= 5'(REF_DEBT_MAX) || !reqValid))
          begin
            d.st = S_REF;
          end
          else if (reqValid)
          begin
            d.wr = reqWrite;
            d.chop = (blMode == BL_FIXED4) || (blMode == BL_OTF && reqChop);
            d.bank = reqBank;
            d.col = reqCol;
            d.data = reqData;
            d.mask = reqMask;
            d.cmd = CMD_ACT;
            d.ba = reqBank;
            d.addr = reqRow;
            d.st = S_ACT;
            d.wait_ = 8'(TRAS_CK - 1);
          end
        end
        S_ACT:
        begin
          d.cmd = q.wr ? CMD_WR : CMD_RD;
          d.ba = q.bank;
          d.addr = q.col;
          d.addr[A12_BIT] = !q.chop;
          d.addr[AP_BIT] = 1'b0;
          d.beats = q.chop ? BEATS_BC4 : BEATS_BL8;
          d.wcnt = q.wr ? 8'(WL_CK + AL) : 8'h00;
          d.st = S_COL;
          d.wait_ = preGap(q.wr, d.beats) - 8'h01;
          if (d.wait_ < 8'(TCCD_CK - 1))
            d.wait_ = 8'(TCCD_CK - 1);
        end
        S_COL:
        begin
          d.cmd = CMD_PRE;
          d.ba = q.bank;
          d.st = S_PRE;
          d.wait_ = 8'(TRC_CK);
        end
        S_REF:
        begin
          d.cmd = CMD_REF;
          d.debt = d.debt - 5'sd1;
          d.st = S_IDLE;
          d.wait_ = 8'(TRFC_CK - 1);
        end
        default:
        begin
          d.st = S_IDLE;
          d.wait_ = 8'(TRP_CK - 1);
        end
      endcase
    end
    // Pull-in never earns credit past eight early refreshes.
    if (d.debt < -5'(REF_DEBT_MAX))
      d.debt = -5'(REF_DEBT_MAX);
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
      q.st <= S_INIT;
      q.cmd <= CMD_NOP;
    end
    else
    begin
      q <= d;
    end
  end

  // Write data is driven for one cycle in the burst window; strobeOk is tied high.
  assign mem.csN = q.cmd[3];
  assign mem.rasN = q.cmd[2];
  assign mem.casN = q.cmd[1];
  assign mem.weN = q.cmd[0];
  assign mem.ba = q.ba;
  assign mem.addr = q.addr;
  assign mem.wdata = q.data;
  assign mem.dm = q.mask;
  assign mem.wvalid = q.wr && q.st == S_COL && q.wcnt == 8'h01;
  assign mem.strobeOk = 1'b1;
  assign reqReady = q.st == S_IDLE && q.wait_ == 8'h00 && !(q.debt >= 5'(REF_DEBT_MAX));
  assign rspData = q.rdat;
  assign rspValid = q.rval;
  assign refBusy = q.st == S_REF;
endmodule

// *** rtl/dtm_if.sv ***
`timescale 1ns/100ps
interface dtm_if #(
  parameter int AW = 14,
  parameter int DW = 8
);
  logic csN;
  logic rasN;
  logic casN;
  logic weN;
  logic [2:0] ba;
  logic [AW-1:0] addr;
  logic [DW-1:0] wdata;
  logic [DW/8-1:0] dm;
  logic wvalid;
  logic strobeOk;
  logic [DW-1:0] rdata;
  logic rvalid;
  modport ctrl (output csN, rasN, casN, weN, ba, addr, wdata, dm, wvalid, strobeOk,
    input rdata, rvalid);
  modport mem (input csN, rasN, casN, weN, ba, addr, wdata, dm, wvalid, strobeOk,
    output rdata, rvalid);
endinterface

// *** rtl/dtm_mem.sv ***
`timescale 1ns/100ps
module dtm_mem
  import dtm_pkg::*;
#(
  parameter int DEPTH = 256,
  parameter int DW = 8
)
(
  input wire logic clk,
  input wire logic rst_n,
  output logic [1:0] burstMode,
  output logic chopLast,
  output logic refreshing,
  dtm_if.mem mem
);
  typedef struct packed {
    logic [1:0] bl;
    logic tdqs;
    logic [7:0] rowCnt;
    logic [7:0] idx;
    logic isWr;
    logic chop;
    logic [DW-1:0] rdat;
    logic rval;
  } dtm_m_s;
  dtm_m_s q;
  dtm_m_s d;
  logic [DW-1:0] store [DEPTH];
  logic [3:0] cmd;
  logic refDone;
  logic wrEn;

  assign cmd = {mem.csN, mem.rasN, mem.casN, mem.weN};

  // Times the refresh cycle so banks read as busy until it completes.
  dtm_bank_timer u_ref (
    .clk(clk),
    .rst_n(rst_n),
    .load(cmd == CMD_REF),
    .value(8'(TRFC_CK)),
    .done(refDone)
  );

  // Decodes commands; refresh ignores address and advances the row counter.
  always_comb
  begin
    d = q;
    d.rval = 1'b0;
    case (cmd)
      CMD_MRS:
      begin
        d.bl = mem.addr[1:0];
        d.tdqs = mem.addr[TDQS_BIT];
      end
      CMD_REF:
      begin
        d.rowCnt = q.rowCnt + 8'h01;
      end
      CMD_RD, CMD_WR:
      begin
        d.idx = mem.addr[7:0];
        d.isWr = cmd == CMD_WR;
        d.chop = q.bl == BL_FIXED4 || (q.bl == BL_OTF && !mem.addr[A12_BIT]);
        d.rval = cmd == CMD_RD;
        d.rdat = store[mem.addr[7:0]];
      end
      default:
      begin
        d.rval = 1'b0;
      end
    endcase
  end

  // A bad strobe only spoils this write's word; masked writes store only when tdqs is set.
  assign wrEn = mem.wvalid && q.isWr && (q.tdqs || !mem.dm[0]) && mem.strobeOk;

  always_ff @(posedge clk)
  begin
    if (wrEn)
    begin
      store[q.idx] <= mem.wdata;
    end
  end

  always_ff @(posedge clk)
  begin
    if (!rst_n)
    begin
      q <= '0;
    end
    else
    begin
      q <= d;
    end
  end

  assign mem.rdata = q.rdat;
  assign mem.rvalid = q.rval;
  assign burstMode = q.bl;
  assign chopLast = q.chop;
  assign refreshing = !refDone;
endmodule

// *** rtl/dtm_pkg.sv ***
package dtm_pkg;
  // Command encodings on {csN, rasN, casN, weN}.
  localparam logic [3:0] CMD_NOP = 4'h7;
  localparam logic [3:0] CMD_ACT = 4'h3;
  localparam logic [3:0] CMD_RD = 4'h5;
  localparam logic [3:0] CMD_WR = 4'h4;
  localparam logic [3:0] CMD_PRE = 4'h2;
  localparam logic [3:0] CMD_REF = 4'h1;
  localparam logic [3:0] CMD_MRS = 4'h0;
  // Burst length field values of mode register 0.
  localparam logic [1:0] BL_FIXED8 = 2'h0;
  localparam logic [1:0] BL_OTF = 2'h1;
  localparam logic [1:0] BL_FIXED4 = 2'h2;
  localparam int A12_BIT = 12;
  localparam int AP_BIT = 10;
  localparam int TDQS_BIT = 11;
  localparam logic [3:0] BEATS_BC4 = 4'h4;
  localparam logic [3:0] BEATS_BL8 = 4'h8;
  // Timing in clocks at 100 MHz.
  localparam int CLK_PS = 10000;
  localparam int TRTP_MIN_PS = 7500;
  localparam int TRTP_MIN_CK = 4;
  localparam int TRTP_PS_CK = (TRTP_MIN_PS + CLK_PS - 1) / CLK_PS;
  localparam int TRTP_CK = (TRTP_PS_CK > TRTP_MIN_CK) ? TRTP_PS_CK : TRTP_MIN_CK;
  localparam int TCCD_CK = 4;
  localparam int TRAS_CK = 4;
  localparam int TRP_CK = 2;
  localparam int TRC_CK = 6;
  localparam int TWR_CK = 2;
  localparam int TWTR_CK = 2;
  localparam int TRFC_CK = 12;
  localparam int TREFI_CK = 780;
  localparam int WL_CK = 5;
  localparam int REF_DEBT_MAX = 8;
  localparam int REF_BURST_MAX = 16;
  localparam logic [7:0] CNT_RST = 8'h00;
endpackage

// *** verif/dtm_assertions.sv ***
`timescale 1ns/100ps
module dtm_assertions
  import dtm_pkg::*;
#(
  parameter int TREFI = 50
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic csN,
  input wire logic rasN,
  input wire logic casN,
  input wire logic weN,
  input wire logic wvalid,
  input wire logic strobeOk
);
  logic [3:0] cmd;
  logic col;
  logic [15:0] refGap_q;
  // Decodes the command lines.
  assign cmd = {csN, rasN, casN, weN};
  assign col = cmd == CMD_RD || cmd == CMD_WR;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  // Counts cycles since the last refresh.
  always_ff @(posedge clk)
  begin
    if (!rst_n || cmd == CMD_REF)
      refGap_q <= '0;
    else
      refGap_q <= refGap_q + 16'h0001;
  end
  property p_rfc; cmd == CMD_REF |=> (cmd == CMD_NOP || csN)[*8]; endproperty
  property p_ccd; col |=> (!col)[*3]; endproperty
  property p_rtp; cmd == CMD_RD |=> (cmd != CMD_PRE)[*3]; endproperty
  property p_ras; cmd == CMD_ACT |=> (cmd != CMD_PRE)[*3]; endproperty
  property p_rc; cmd == CMD_ACT |=> (cmd != CMD_ACT)[*5]; endproperty
  property p_rp; cmd == CMD_PRE |=> (cmd != CMD_ACT && cmd != CMD_REF)[*2]; endproperty
  property p_wr; wvalid |=> (cmd != CMD_PRE)[*2]; endproperty
  property p_wtr; wvalid |=> (cmd != CMD_RD)[*2]; endproperty
  property p_refi; refGap_q <= 16'(9 * TREFI); endproperty
  property p_dqs; cmd == CMD_WR |-> ##[1:5] (wvalid && strobeOk); endproperty
  a_rfc: assert property (p_rfc)
    else $error("command inside refresh cycle");
  a_ccd: assert property (p_ccd)
    else $error("column commands too close");
  a_rtp: assert property (p_rtp)
    else $error("precharge too soon after read");
  a_ras: assert property (p_ras)
    else $error("precharge too soon after activate");
  a_rc: assert property (p_rc)
    else $error("activate too soon after activate");
  a_rp: assert property (p_rp)
    else $error("command too soon after precharge");
  a_wr: assert property (p_wr)
    else $error("precharge too soon after write data");
  a_wtr: assert property (p_wtr)
    else $error("read too soon after write data");
  a_refi: assert property (p_refi)
    else $error("refresh gap too long");
  a_dqs: assert property (p_dqs)
    else $error("write beat with bad strobe timing");
  c_ref: cover property (cmd == CMD_REF);
  c_rd: cover property (cmd == CMD_RD);
  c_wr: cover property (wvalid);
endmodule

// *** verif/tb_top.sv ***
`timescale 1ns/100ps
module tb_top
  import dtm_pkg::*;
();
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic reqValid = 1'b0;
  logic reqWrite = 1'b0;
  logic reqChop = 1'b0;
  logic [2:0] reqBank = 3'h0;
  logic [13:0] reqRow = 14'h0000;
  logic [13:0] reqCol = 14'h0000;
  logic [7:0] reqData = 8'h00;
  logic [0:0] reqMask = 1'h0;
  logic [1:0] blMode = BL_FIXED8;
  logic reqReady, rspValid, refBusy, chopLast, memRefr;
  logic [7:0] rspData;
  logic [1:0] burstMode;
  logic [1:0] modes [3] = '{BL_FIXED8, BL_OTF, BL_FIXED4};
  logic [7:0] expQ[$];
  logic a12Q[$];
  logic dmQ[$];
  logic chopQ[$];
  logic colSeen = 1'b0;
  logic refBusyQ = 1'b0;
  logic [7:0] memM[int];
  int error_cnt = 0;
  int tests_run = 0;
  int refCnt = 0;
  logic refSeen = 1'b0;
  logic [3:0] cmd;
  dtm_if #(.AW(14), .DW(8)) bus ();
  assign cmd = {bus.csN, bus.rasN, bus.casN, bus.weN};
  // Free-running clock.
  always #5 clk = ~clk;
  dtm_ctrl #(.AL(0), .TREFI(50)) i_dtm_ctrl (.clk(clk), .rst_n(rst_n), .reqValid(reqValid),
    .reqWrite(reqWrite), .reqChop(reqChop), .reqBank(reqBank), .reqRow(reqRow),
    .reqCol(reqCol), .reqData(reqData), .reqMask(reqMask), .blMode(blMode),
    .reqReady(reqReady), .rspData(rspData), .rspValid(rspValid), .refBusy(refBusy),
    .mem(bus));
  dtm_mem i_dtm_mem (.clk(clk), .rst_n(rst_n), .burstMode(burstMode), .chopLast(chopLast),
    .refreshing(memRefr), .mem(bus));
  dtm_assertions #(.TREFI(50)) i_dtm_assertions (.clk(clk), .rst_n(rst_n), .csN(bus.csN),
    .rasN(bus.rasN), .casN(bus.casN), .weN(bus.weN), .wvalid(bus.wvalid),
    .strobeOk(bus.strobeOk));
  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // Prints the verdict and stops.
  task automatic complete_run();
    if (error_cnt == 0 && tests_run > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // Issues one access and notes what it should produce.
  task automatic access(input logic w, input logic [7:0] c, input logic [7:0] d, input logic m);
    int n;
    logic ch;
    n = 0;
    ch = 1'($urandom);
    @(posedge clk);
    reqValid <= 1'b1;
    reqWrite <= w;
    reqChop <= ch;
    reqBank <= 3'($urandom);
    reqRow <= 14'($urandom);
    reqCol <= {6'h00, c};
    reqData <= d;
    reqMask <= m;
    do @(negedge clk) n++; while (reqReady !== 1'b1 && n < 400);
    if (n >= 400)
    begin
      check("reqReady", 8'(reqReady), 8'h01);
      complete_run();
    end
    @(posedge clk);
    reqValid <= 1'b0;
    if (blMode == BL_OTF) a12Q.push_back(!ch);
    chopQ.push_back(blMode == BL_FIXED4 || (blMode == BL_OTF && ch));
    if (w) dmQ.push_back(m);
    if (w && !m) memM[c] = d;
    if (!w) expQ.push_back(memM[c]);
  endtask
  // Watches responses and the wire against the notes.
  always @(posedge clk)
  begin
    if (rspValid === 1'b1) check("rspData", rspData, expQ.size() ? expQ.pop_front() : 8'hxx);
    if (rst_n && blMode == BL_OTF && (cmd == CMD_RD || cmd == CMD_WR))
      check("A12", 8'(bus.addr[A12_BIT]), a12Q.size() ? 8'(a12Q.pop_front()) : 8'hxx);
    if (bus.wvalid === 1'b1) check("dm", 8'(bus.dm), dmQ.size() ? 8'(dmQ.pop_front()) : 8'hxx);
    if (refSeen) check("refreshing", 8'(memRefr), 8'h01);
    if (colSeen)
      check("chopLast", 8'(chopLast), chopQ.size() ? 8'(chopQ.pop_front()) : 8'hxx);
    if (rst_n && refBusyQ) check("refBusy", 8'(cmd == CMD_REF), 8'h01);
    colSeen <= rst_n && (cmd == CMD_RD || cmd == CMD_WR);
    refBusyQ <= rst_n && refBusy;
    refSeen <= rst_n && cmd == CMD_REF;
    if (rst_n && cmd == CMD_REF) refCnt++;
  end
  // Runs each burst mode, then an idle stretch for refresh.
  initial
  begin
    int unsigned s;
    s = $urandom(32'h479f);
    for (int k = 0; k < 3; k++)
    begin
      blMode <= modes[k];
      rst_n <= 1'b0;
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      repeat (6) @(posedge clk);
      check("burstMode", 8'(burstMode), 8'(modes[k]));
      for (int i = 0; i < 12; i++) access(1'b1, 8'(i), 8'($urandom), 1'b0);
      access(1'b1, 8'h03, 8'hee, 1'b1);
      for (int i = 0; i < 12; i++) access(1'b0, 8'(i), 8'h00, 1'b0);
      repeat (30) @(posedge clk);
      check("pending", 8'(expQ.size()), 8'h00);
    end
    refCnt = 0;
    repeat (900) @(posedge clk);
    check("refreshes", 8'(refCnt >= 17 && refCnt <= 27), 8'h01);
    complete_run();
  end
endmodule
